// >>> hw/mba_defines.svh
// Offsets, field positions, reset values and widths for the bus arbitration block.
`ifndef MBA_DEFINES_SVH
`define MBA_DEFINES_SVH
`define MBA_ADDR_W          12
`define MBA_OFF_SYSCFG      12'h000
`define MBA_OFF_STATUS      12'h004
`define MBA_OFF_ACCESS      12'h008
`define MBA_SYSCFG_ADRV_BIT 0
`define MBA_SYSCFG_BGND_BIT 1
`define MBA_SYSCFG_RST      32'h00000000
`define MBA_ACCESS_DONE_BIT 0
`define MBA_NUM_REQ         6
`define MBA_ID_W            3
`define MBA_ID_SOLO         3'h0
`endif

// >>> hw/mba_pkg.sv
// Types shared by the bus arbitration block.
package mba_pkg;
    typedef logic [2:0] mba_id_t;
    typedef logic [5:0] mba_req_t;
    typedef enum logic [1:0] {
        MBA_OWN_NONE,
        MBA_OWN_SELF,
        MBA_OWN_OTHER,
        MBA_OWN_HOST
    } mba_owner_e;
    typedef enum {
        MBA_AS_IDLE,
        MBA_AS_WAIT,
        MBA_AS_DONE
    } mba_acc_e;
endpackage

// >>> hw/mba_prio.sv
// Priority pick of one bus request, fixed or rotating from the last owner.
`timescale 1ns/1ps
module mba_prio #(
    parameter int N = 6
) (
    input  wire logic [N-1:0]         req,
    input  wire logic                 rotate,
    input  wire logic [2:0]           last,
    output logic                      found,
    output logic [2:0]                win
);
    // Lowest index wins in fixed mode; rotating mode starts after the last owner.
    always_comb begin
        int start;
        int k;
        start = 0;
        k     = 0;
        found = 1'b0;
        win   = 3'h0;
        if (rotate) begin
            start = int'(last) + 1;
        end
        for (int i = 0; i < N; i++) begin
            k = (start + i) % N;
            if (!found && req[k]) begin
                found = 1'b1;
                win   = 3'(k);
            end
        end
    end
endmodule // mba_prio

// >>> hw/mba_arbiter.sv
// Shared external bus arbiter with host acknowledge and APB registers.
`timescale 1ns/1ps
`include "mba_defines.svh"
module mba_arbiter #(
    parameter int NREQ = `MBA_NUM_REQ
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire mba_pkg::mba_id_t     processor_identity,
    input  wire logic                 rotating_priority_sel,
    input  wire mba_pkg::mba_req_t    bus_request_lines_n,
    output logic                      own_bus_request_n_o,
    output logic                      own_bus_request_oe,
    input  wire logic                 want_bus,
    input  wire logic                 background_xfer,
    output logic                      bus_master,
    output logic                      bus_drive_en,
    output logic                      background_suspend,
    input  wire logic                 core_priority_access_n_i,
    output logic                      core_priority_access_n_o,
    output logic                      core_priority_access_oe,
    input  wire logic                 core_priority_want,
    input  wire logic                 host_bus_request_n,
    input  wire logic                 host_chip_select_n,
    output logic                      host_bus_grant_n,
    output logic                      host_access_ack_o,
    output logic                      host_access_ack_oe,
    input  wire logic                 host_access_pending
);
    import mba_pkg::*;

    logic [31:0]   syscfg_q;
    mba_id_t       id_q;
    mba_id_t       last_q;
    mba_owner_e    owner_q;
    mba_owner_e    owner_d;
    mba_acc_e      acc_q;
    mba_req_t      req_s;
    mba_req_t      others;
    logic          found;
    logic          keep;
    mba_id_t       win;
    logic          solo;
    logic          host_req;
    logic          host_sel;
    logic          ack_low;
    logic          apb_wr;
    logic          apb_rd;

    function automatic logic mba_onehot_match(input mba_id_t id, input int line);
        mba_onehot_match = (id != `MBA_ID_SOLO) && (int'(id) == line + 1);
    endfunction

    assign apb_wr   = psel && penable && pwrite;
    assign apb_rd   = psel && !penable && !pwrite;
    assign solo     = (id_q == `MBA_ID_SOLO);
    assign host_req = !host_bus_request_n;
    assign host_sel = host_req && !host_chip_select_n;

    // Identity is caught once reset releases and the bus is idle; a nonzero identity then stays fixed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_q <= 3'h0;
        end else if (!bus_master && owner_q == MBA_OWN_NONE && id_q == 3'h0) begin
            id_q <= processor_identity;
        end
    end

    always_comb begin
        req_s = ~bus_request_lines_n;
        for (int i = 0; i < NREQ; i++) begin
            if (mba_onehot_match(id_q, i)) begin
                req_s[i] = want_bus;
            end
        end
        others = req_s;
    end

    mba_prio #(
        .N      (NREQ)
    ) u_prio (
        .req    (others),
        .rotate (rotating_priority_sel),
        .last   (last_q),
        .found  (found),
        .win    (win)
    );

    // The owner keeps the bus only while its own line still requests, so a
    // departing master cannot lock out the remaining requesters.
    assign keep = (owner_q == MBA_OWN_SELF && want_bus) ||
                  (owner_q == MBA_OWN_OTHER && others[last_q]);

    // Ownership decision, identical on every processor.
    always_comb begin
        owner_d = MBA_OWN_NONE;
        if (host_req) begin
            owner_d = MBA_OWN_HOST;
        end else if (keep) begin
            owner_d = owner_q;
        end else if (solo) begin
            owner_d = want_bus ? MBA_OWN_SELF : MBA_OWN_NONE;
        end else if (found) begin
            owner_d = mba_onehot_match(id_q, int'(win)) ? MBA_OWN_SELF : MBA_OWN_OTHER;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_q <= MBA_OWN_NONE;
            last_q  <= 3'h5;
        end else begin
            owner_q <= owner_d;
            if (found && !host_req && !keep && !solo) begin
                last_q <= win;
            end
        end
    end

    // drive only own line, none when solo.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_bus_request_n_o <= 1'b1;
            own_bus_request_oe  <= 1'b0;
        end else begin
            own_bus_request_n_o <= !want_bus;
            own_bus_request_oe  <= !solo && (id_q <= 3'(NREQ));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_master       <= 1'b0;
            bus_drive_en     <= 1'b0;
            host_bus_grant_n <= 1'b1;
        end else begin
            bus_master       <= (owner_d == MBA_OWN_SELF);
            bus_drive_en     <= (owner_d == MBA_OWN_SELF);
            host_bus_grant_n <= !(owner_d == MBA_OWN_HOST);
        end
    end

    // suspend background work for core priority.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            background_suspend       <= 1'b0;
            core_priority_access_n_o <= 1'b0;
            core_priority_access_oe  <= 1'b0;
        end else begin
            background_suspend       <= (owner_d == MBA_OWN_SELF) && background_xfer &&
                                        !core_priority_access_n_i && !core_priority_want &&
                                        syscfg_q[`MBA_SYSCFG_BGND_BIT];
            core_priority_access_n_o <= 1'b0;
            core_priority_access_oe  <= core_priority_want && !bus_master;
        end
    end

    // Host access tracking: wait until the core side completes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= MBA_AS_IDLE;
        end else begin
            case (acc_q)
                MBA_AS_IDLE: begin
                    if (host_sel && host_access_pending) begin
                        acc_q <= MBA_AS_WAIT;
                    end
                end
                MBA_AS_WAIT: begin
                    if (!host_sel) begin
                        acc_q <= MBA_AS_IDLE;
                    end else if (!host_access_pending) begin
                        acc_q <= MBA_AS_DONE;
                    end
                end
                MBA_AS_DONE: begin
                    if (!host_sel || host_access_pending) begin
                        acc_q <= host_sel ? MBA_AS_WAIT : MBA_AS_IDLE;
                    end
                end
                default: acc_q <= MBA_AS_IDLE;
            endcase
        end
    end

    // low while the access cannot finish.
    assign ack_low = host_sel && host_access_pending;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_access_ack_o  <= 1'b0;
            host_access_ack_oe <= 1'b0;
        end else begin
            host_access_ack_o <= !ack_low;
            // drive only when selected: low during a wait state, high only in drive mode.
            host_access_ack_oe <= host_sel &&
                                  (ack_low || syscfg_q[`MBA_SYSCFG_ADRV_BIT]);
        end
    end

    // APB configuration register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syscfg_q <= `MBA_SYSCFG_RST;
        end else if (apb_wr && paddr == `MBA_OFF_SYSCFG) begin
            syscfg_q <= {30'h00000000, pwdata[1:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != `MBA_OFF_SYSCFG &&
                       paddr != `MBA_OFF_STATUS && paddr != `MBA_OFF_ACCESS;
            if (apb_rd) begin
                case (paddr)
                    `MBA_OFF_SYSCFG: prdata <= syscfg_q;
                    `MBA_OFF_STATUS: prdata <= {19'h00000, last_q, id_q, 2'(owner_q),
                                                3'h0, host_req, bus_master};
                    `MBA_OFF_ACCESS: prdata <= {31'h00000000, acc_q == MBA_AS_DONE};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // mba_arbiter

// >>> tb/mba_far_side.sv
// Model of the other processors on the request lines and the wired priority line.
`timescale 1ns/1ps
module mba_far_side (
    input  wire logic       own_n,
    input  wire logic       own_oe,
    input  wire logic [2:0] id,
    input  wire logic [5:0] other_n,
    input  wire logic       cpa_oe,
    input  wire logic       cpa_n,
    input  wire logic       other_cpa,
    output logic      [5:0] lines_n,
    output logic            cpa_line_n
);
    always_comb begin
        lines_n = other_n;
        if (own_oe && id != 3'h0) begin
            lines_n[id - 3'h1] = own_n;
        end
    end
    assign cpa_line_n = !(cpa_oe && !cpa_n) && !other_cpa;
endmodule // mba_far_side

// >>> tb/mba_arbiter_assertions.sv
// Checker of arbitration and host acknowledge behaviour at the arbiter ports.
`timescale 1ns/1ps
module mba_arbiter_assertions (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire mba_pkg::mba_id_t processor_identity,
    input wire logic             own_bus_request_oe,
    input wire logic             bus_master,
    input wire logic             bus_drive_en,
    input wire logic             background_suspend,
    input wire logic             core_priority_access_n_i,
    input wire logic             host_bus_request_n,
    input wire logic             host_chip_select_n,
    input wire logic             host_bus_grant_n,
    input wire logic             host_access_ack_o,
    input wire logic             host_access_ack_oe,
    input wire logic             host_access_pending
);
    import mba_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ack_gate: assert property (
        host_access_ack_oe |-> $past(!host_chip_select_n && !host_bus_request_n))
        else $error("ack driven without select and request");
    a_ack_wait: assert property (
        (!host_chip_select_n && !host_bus_request_n && host_access_pending)
        |=> (!host_access_ack_o && host_access_ack_oe))
        else $error("no wait state on pending host access");
    a_ack_release: assert property (
        !host_access_pending |=> !(host_access_ack_oe && !host_access_ack_o))
        else $error("wait state held after access done");
    a_solo_quiet: assert property (
        processor_identity == 3'h0 |-> !own_bus_request_oe)
        else $error("solo processor drives a request line");
    a_host_first: assert property (
        !host_bus_request_n [*2] |-> !bus_master)
        else $error("processor kept bus against host");
    a_host_tristate: assert property (
        $fell(host_bus_request_n) ##1 !host_bus_request_n |-> !bus_drive_en)
        else $error("bus still driven during host request");
    a_host_release: assert property (
        host_bus_request_n |=> host_bus_grant_n)
        else $error("grant held after host released");
    a_bg_cause: assert property (
        background_suspend |-> $past(!core_priority_access_n_i))
        else $error("suspend without core priority line");
    c_host: cover property (!host_bus_grant_n);
    c_wait: cover property (host_access_ack_oe && !host_access_ack_o);
    c_susp: cover property (background_suspend);
endmodule // mba_arbiter_assertions
bind mba_arbiter mba_arbiter_assertions i_mba_arbiter_assertions (.*);

// >>> tb/testbench.sv
// Bench for the bus arbiter: registers, arbitration, host grant and acknowledge.
`timescale 1ns/1ps
module testbench;
    import mba_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    mba_id_t     processor_identity;
    mba_req_t    bus_request_lines_n, other_n;
    logic        rotating_priority_sel, own_bus_request_n_o, own_bus_request_oe, other_cpa;
    logic        want_bus, background_xfer, bus_master, bus_drive_en, background_suspend;
    logic        core_priority_access_n_i, core_priority_access_n_o, core_priority_access_oe;
    logic        core_priority_want, host_bus_request_n, host_chip_select_n, host_bus_grant_n;
    logic        host_access_ack_o, host_access_ack_oe, host_access_pending;
    int          n_errors = 0;
    int          n_compared = 0;
    int          k;
    mba_arbiter i_mba_arbiter (.*);
    mba_far_side i_mba_far_side (
        .own_n(own_bus_request_n_o),
        .own_oe(own_bus_request_oe),
        .id(processor_identity),
        .other_n(other_n),
        .cpa_oe(core_priority_access_oe),
        .cpa_n(core_priority_access_n_o),
        .other_cpa(other_cpa),
        .lines_n(bus_request_lines_n),
        .cpa_line_n(core_priority_access_n_i)
    );
    always #20 pclk = ~pclk;
    task summarize;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task tmo;
        if (k >= 40) begin
            n_errors++;
            $display("BAD %0t wait ran out", $time);
            summarize;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo;
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, want_bus, background_xfer, core_priority_want} = '0;
        {paddr, pwdata} = '0;
        {host_bus_request_n, host_chip_select_n, host_access_pending, other_cpa} = 4'hC;
        processor_identity = 3'h3;
        other_n = 6'h3F;
        rotating_priority_sel = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(host_bus_grant_n, 1'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h00C, 32'h0);
        chk(er, 1'h1);
        chk(rd, 32'h0);
        $display("test registers done");
        want_bus <= 1'b1;
        k = 0;
        while (bus_master !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k++;
        end
        tmo;
        chk(bus_request_lines_n, 6'h3B);
        chk(own_bus_request_oe, 1'h1);
        background_xfer <= 1'b1;
        other_cpa <= 1'b1;
        k = 0;
        while (background_suspend !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k++;
        end
        tmo;
        chk(background_suspend, 1'h1);
        background_xfer <= 1'b0;
        other_cpa <= 1'b0;
        rotating_priority_sel <= 1'b1;
        want_bus <= 1'b0;
        other_n <= 6'h36;
        repeat (2) @(posedge pclk);
        chk(bus_master, 1'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h00000DC0);
        rotating_priority_sel <= 1'b0;
        want_bus <= 1'b1;
        other_n <= 6'h2F;
        repeat (2) @(posedge pclk);
        chk(bus_master, 1'h1);
        other_n <= 6'h3F;
        host_bus_request_n <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({bus_master, bus_drive_en, host_bus_grant_n}, 3'h0);
        $display("test arbitration done");
        host_chip_select_n <= 1'b0;
        host_access_pending <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({host_access_ack_oe, host_access_ack_o}, 2'h2);
        host_access_pending <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({host_access_ack_oe, host_access_ack_o}, 2'h3);
        host_chip_select_n <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(host_access_ack_oe, 1'h0);
        host_bus_request_n <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(host_bus_grant_n, 1'h1);
        $display("test host done");
        presetn <= 1'b0;
        processor_identity <= 3'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({own_bus_request_oe, bus_request_lines_n}, 7'h3F);
        host_bus_request_n <= 1'b0;
        host_chip_select_n <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({host_access_ack_oe, host_access_ack_o}, 2'h1);
        $display("test solo done");
        summarize;
    end
endmodule // testbench
